/* hw/timer_pair_pkg.sv */
// package with register map, field layout and types of the dual reload timer pair
package timer_pair_pkg;

  // =====================================================================
  // register indices as printed; byte address is four times the index
  // =====================================================================
  localparam logic [7:0] TIMER_FIVE_CONTROL_IDX = 8'hc0;
  localparam logic [7:0] TIMER_FOUR_CONTROL_IDX = 8'hc8;
  localparam logic [7:0] TIMER_FOUR_LOW_IDX = 8'hcc;
  localparam logic [7:0] TIMER_FOUR_HIGH_IDX = 8'hcd;
  localparam logic [7:0] TIMER_FIVE_LOW_IDX = 8'hce;
  localparam logic [7:0] TIMER_FIVE_HIGH_IDX = 8'hcf;
  localparam logic [7:0] TIMER_FIVE_IRQ_ENABLE_IDX = 8'hd0;
  localparam int ADDR_W = 12;

  // =====================================================================
  // field positions
  // =====================================================================
  localparam int FLAG_BIT = 7;
  localparam int CMP_BIT = 6;
  localparam int PS_LSB = 4;
  localparam int MODE_LSB = 2;
  localparam int RUN_BIT = 1;
  localparam int CLKS_BIT = 0;
  localparam int IRQ_EN_BIT = 0;

  // =====================================================================
  // reset values and prescale terminal counts
  // =====================================================================
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:0] DIV_1_LAST = 8'h00;
  localparam logic [7:0] DIV_8_LAST = 8'h07;
  localparam logic [7:0] DIV_64_LAST = 8'h3f;
  localparam logic [7:0] DIV_256_LAST = 8'hff;
  localparam logic [15:0] COUNT_TOP = 16'hffff;

  // =====================================================================
  // types
  // =====================================================================
  typedef enum logic [1:0] {
    MODE_RELOAD = 2'b00,
    MODE_BAUD = 2'b01,
    MODE_RISE_TRIG = 2'b10,
    MODE_FALL_TRIG = 2'b11
  } t4_mode_t;

  typedef struct packed {
    logic timer_four_overflow_flag;
    logic compare_or_retrigger_bit;
    logic [1:0] timer_four_prescale;
    t4_mode_t timer_four_mode_field;
    logic timer_four_run_bit;
    logic clock_source_select;
  } t4_ctl_t;

  typedef struct packed {
    logic timer_five_overflow_flag;
    logic unused6;
    logic [1:0] timer_five_prescale;
    logic [1:0] unused3;
    logic timer_five_run_bit;
    logic unused0;
  } t5_ctl_t;

  typedef enum {
    TRIG_WAIT,
    TRIG_COUNT
  } trig_state_t;

endpackage : timer_pair_pkg

/* hw/dual_reload_timer_pair.sv */
// two 16-bit auto-reload up timers with an apb register slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - timer four flag set on wrap except in baud mode, bit 7; hardware clear input also clears it
// - reload mode: compare bit enables compare function
// - edge modes: retrigger edges restart count only when compare bit set
// - timer four prescale 00,01,10,11 divide by 1,8,64,256
// - mode 00 reload counter/timer, mode 01 baud generator
// - mode 10 starts on rising pin edge, system clock only
// - mode 11 starts on falling pin edge, system clock only
// - timer four run bit 0 stops, 1 runs
// - clock source 0 system clock; 1 falling pin edges, plus pull-up unless compare is on
// - timer five byte writes go to load register, reads return counter
// - timer five wrap sets flag and reloads counter from load register
// - high byte write also copies whole load register into counter
// - timer five overflow raises interrupt request only when enabled
// - timer five clock source follows timer four clock source bit
// - timer five run bit counts upward from present value
// - setting run never clears the counter
// - high byte is counter bits 15:8, low byte bits 7:0
// - baud mode reloads on overflow but raises no interrupt
// - edge mode waits for edge, after overflow flags, reloads, holds
// - compare on: pin driven as output and toggled each overflow
// - timer five prescale 00,01,10,11 divide by 1,8,64,256
module dual_reload_timer_pair (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // timer four pin
  input wire logic timer_four_pin_i,
  output logic timer_four_pin_o,
  output logic timer_four_pin_oe_n_o,
  output logic timer_four_pull_up_o,
  // hardware flag clears from the interrupt controller
  input wire logic timer_four_flag_clear_i,
  input wire logic timer_five_flag_clear_i,
  // event outputs
  output logic timer_four_irq_o,
  output logic timer_five_irq_o,
  output logic baud_tick_o
);
  import timer_pair_pkg::*;

  // =====================================================================
  // helpers
  // =====================================================================
  function automatic logic [7:0] presc_last(input logic [1:0] ps);
    case (ps)
      2'b00: presc_last = DIV_1_LAST;
      2'b01: presc_last = DIV_8_LAST;
      2'b10: presc_last = DIV_64_LAST;
      default: presc_last = DIV_256_LAST;
    endcase
  endfunction : presc_last

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction : byte_addr

  // =====================================================================
  // state
  // =====================================================================
  t4_ctl_t t4_ctl_reg;
  t5_ctl_t t5_ctl_reg;
  logic t5_irq_en_reg;
  logic [15:0] t4_load_reg;
  logic [15:0] t4_count_reg;
  logic [15:0] t5_load_reg;
  logic [15:0] t5_count_reg;
  logic [7:0] t4_presc_reg;
  logic [7:0] t5_presc_reg;
  logic pin_prev_reg;
  trig_state_t trig_state_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pin_out_reg;
  logic pin_oe_n_reg;
  logic pull_up_reg;
  logic t4_irq_reg;
  logic t5_irq_reg;
  logic baud_tick_reg;

  // =====================================================================
  // bus decode
  // =====================================================================
  logic setup;
  logic access;
  logic wr;
  logic lane0;
  logic [7:0] wbyte;
  logic sel_t4c, sel_t4l, sel_t4h, sel_t5c, sel_t5l, sel_t5h, sel_ien;
  logic mapped;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_reg;
  assign wr = access & pwrite_i & lane0;
  assign lane0 = pstrb_i[0];
  assign wbyte = pwdata_i[7:0];
  assign sel_t4c = paddr_i == byte_addr(TIMER_FOUR_CONTROL_IDX);
  assign sel_t4l = paddr_i == byte_addr(TIMER_FOUR_LOW_IDX);
  assign sel_t4h = paddr_i == byte_addr(TIMER_FOUR_HIGH_IDX);
  assign sel_t5c = paddr_i == byte_addr(TIMER_FIVE_CONTROL_IDX);
  assign sel_t5l = paddr_i == byte_addr(TIMER_FIVE_LOW_IDX);
  assign sel_t5h = paddr_i == byte_addr(TIMER_FIVE_HIGH_IDX);
  assign sel_ien = paddr_i == byte_addr(TIMER_FIVE_IRQ_ENABLE_IDX);
  assign mapped = sel_t4c | sel_t4l | sel_t4h | sel_t5c | sel_t5l | sel_t5h | sel_ien;

  // =====================================================================
  // count enables
  // =====================================================================
  logic pin_fall;
  logic pin_rise;
  logic t4_edge_mode;
  logic t4_src;
  logic t5_src;
  logic t4_tick;
  logic t5_tick;
  logic t4_active;
  logic t4_wrap;
  logic t5_wrap;
  logic trig_edge;
  logic t4_hi_wr;
  logic t5_hi_wr;

  assign pin_fall = pin_prev_reg & ~timer_four_pin_i;
  assign pin_rise = ~pin_prev_reg & timer_four_pin_i;
  assign t4_edge_mode = t4_ctl_reg.timer_four_mode_field[1];
  // edge modes ignore the source bit and use the system clock
  assign t4_src = (t4_ctl_reg.clock_source_select & ~t4_edge_mode) ? pin_fall : 1'b1;
  assign t5_src = t4_ctl_reg.clock_source_select ? pin_fall : 1'b1;
  assign trig_edge = (t4_ctl_reg.timer_four_mode_field == MODE_RISE_TRIG) ? pin_rise : pin_fall;
  assign t4_active = t4_ctl_reg.timer_four_run_bit & (~t4_edge_mode | trig_state_reg == TRIG_COUNT);
  assign t4_tick = t4_active & t4_src & (t4_presc_reg == presc_last(t4_ctl_reg.timer_four_prescale));
  assign t5_tick = t5_ctl_reg.timer_five_run_bit & t5_src
    & (t5_presc_reg == presc_last(t5_ctl_reg.timer_five_prescale));
  assign t4_wrap = t4_tick & (t4_count_reg == COUNT_TOP);
  assign t5_wrap = t5_tick & (t5_count_reg == COUNT_TOP);
  assign t4_hi_wr = wr & sel_t4h;
  assign t5_hi_wr = wr & sel_t5h;

  // =====================================================================
  // apb answer: registered, one access cycle per transfer
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en_i) begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup && !pwrite_i) begin
        // reads of the data bytes return the live counter
        case (1'b1)
          sel_t4c: prdata_reg <= {24'h00_0000, t4_ctl_reg};
          sel_t4l: prdata_reg <= {24'h00_0000, t4_count_reg[7:0]};
          sel_t4h: prdata_reg <= {24'h00_0000, t4_count_reg[15:8]};
          sel_t5c: prdata_reg <= {24'h00_0000, t5_ctl_reg.timer_five_overflow_flag, 1'b0,
                                  t5_ctl_reg.timer_five_prescale, 2'b00, t5_ctl_reg.timer_five_run_bit, 1'b0};
          sel_t5l: prdata_reg <= {24'h00_0000, t5_count_reg[7:0]};
          sel_t5h: prdata_reg <= {24'h00_0000, t5_count_reg[15:8]};
          sel_ien: prdata_reg <= {31'h0000_0000, t5_irq_en_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // =====================================================================
  // timer four control; hardware set beats any clear
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t4_ctl_reg <= t4_ctl_t'(CONTROL_RESET);
    end else if (clk_en_i) begin
      if (wr && sel_t4c) begin
        t4_ctl_reg <= t4_ctl_t'(wbyte);
      end else if (timer_four_flag_clear_i) begin
        t4_ctl_reg.timer_four_overflow_flag <= 1'b0;
      end
      if (t4_wrap && t4_ctl_reg.timer_four_mode_field != MODE_BAUD) begin
        t4_ctl_reg.timer_four_overflow_flag <= 1'b1;
      end
    end
  end

  // =====================================================================
  // timer five control and interrupt enable
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t5_ctl_reg <= t5_ctl_t'(CONTROL_RESET);
      t5_irq_en_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (wr && sel_ien) begin
        t5_irq_en_reg <= wbyte[IRQ_EN_BIT];
      end
      if (wr && sel_t5c) begin
        t5_ctl_reg <= t5_ctl_t'({wbyte[FLAG_BIT], 1'b0, wbyte[PS_LSB+1:PS_LSB], 2'b00, wbyte[RUN_BIT], 1'b0});
      end else if (timer_five_flag_clear_i) begin
        t5_ctl_reg.timer_five_overflow_flag <= 1'b0;
      end
      if (t5_wrap) begin
        t5_ctl_reg.timer_five_overflow_flag <= 1'b1;
      end
    end
  end

  // =====================================================================
  // prescalers, restart when idle
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t4_presc_reg <= 8'h00;
    end else if (clk_en_i) begin
      if (!t4_active) begin
        t4_presc_reg <= 8'h00;
      end else if (t4_src) begin
        t4_presc_reg <= t4_tick ? 8'h00 : t4_presc_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t5_presc_reg <= 8'h00;
    end else if (clk_en_i) begin
      if (!t5_ctl_reg.timer_five_run_bit) begin
        t5_presc_reg <= 8'h00;
      end else if (t5_src) begin
        t5_presc_reg <= t5_tick ? 8'h00 : t5_presc_reg + 8'h01;
      end
    end
  end

  // =====================================================================
  // pin edge history
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_prev_reg <= 1'b1; // idle high under the pull-up, no false edge after reset
    end else if (clk_en_i) begin
      pin_prev_reg <= timer_four_pin_i;
    end
  end

  // =====================================================================
  // trigger state for the edge modes
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_state_reg <= TRIG_WAIT;
    end else if (clk_en_i) begin
      case (trig_state_reg)
        TRIG_WAIT: begin
          if (t4_ctl_reg.timer_four_run_bit && t4_edge_mode && trig_edge) begin
            trig_state_reg <= TRIG_COUNT;
          end
        end
        TRIG_COUNT: begin
          if (!t4_ctl_reg.timer_four_run_bit || !t4_edge_mode || t4_wrap) begin
            trig_state_reg <= TRIG_WAIT;
          end
        end
        default: trig_state_reg <= TRIG_WAIT;
      endcase
    end
  end

  // =====================================================================
  // timer four load and counter
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t4_load_reg <= DATA_RESET;
      t4_count_reg <= DATA_RESET;
    end else if (clk_en_i) begin
      if (wr && sel_t4l) begin
        t4_load_reg[7:0] <= wbyte;
      end
      if (t4_hi_wr) begin
        t4_load_reg[15:8] <= wbyte;
        t4_count_reg <= {wbyte, t4_load_reg[7:0]};
      end else if (t4_wrap) begin
        t4_count_reg <= t4_load_reg;
      end else if (trig_state_reg == TRIG_COUNT && t4_ctl_reg.timer_four_run_bit && t4_edge_mode
                   && trig_edge && t4_ctl_reg.compare_or_retrigger_bit) begin
        t4_count_reg <= t4_load_reg;
      end else if (t4_tick) begin
        t4_count_reg <= t4_count_reg + 16'h0001;
      end
    end
  end

  // =====================================================================
  // timer five load and counter
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t5_load_reg <= DATA_RESET;
      t5_count_reg <= DATA_RESET;
    end else if (clk_en_i) begin
      if (wr && sel_t5l) begin
        t5_load_reg[7:0] <= wbyte;
      end
      if (t5_hi_wr) begin
        t5_load_reg[15:8] <= wbyte;
        t5_count_reg <= {wbyte, t5_load_reg[7:0]};
      end else if (t5_wrap) begin
        t5_count_reg <= t5_load_reg;
      end else if (t5_tick) begin
        t5_count_reg <= t5_count_reg + 16'h0001;
      end
    end
  end

  // =====================================================================
  // pin drive: compare output and pull-up
  // =====================================================================
  logic cmp_on;
  assign cmp_on = t4_ctl_reg.timer_four_mode_field == MODE_RELOAD & t4_ctl_reg.compare_or_retrigger_bit;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      pull_up_reg <= 1'b0;
    end else if (clk_en_i) begin
      pin_oe_n_reg <= ~cmp_on;
      pull_up_reg <= t4_ctl_reg.clock_source_select & ~cmp_on;
      if (cmp_on && t4_wrap) begin
        pin_out_reg <= ~pin_out_reg;
      end
    end
  end

  // =====================================================================
  // interrupt requests and baud tick
  // =====================================================================
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t4_irq_reg <= 1'b0;
      t5_irq_reg <= 1'b0;
      baud_tick_reg <= 1'b0;
    end else if (clk_en_i) begin
      t4_irq_reg <= t4_ctl_reg.timer_four_overflow_flag;
      t5_irq_reg <= t5_ctl_reg.timer_five_overflow_flag & t5_irq_en_reg;
      baud_tick_reg <= t4_wrap & (t4_ctl_reg.timer_four_mode_field == MODE_BAUD);
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign timer_four_pin_o = pin_out_reg;
  assign timer_four_pin_oe_n_o = pin_oe_n_reg;
  assign timer_four_pull_up_o = pull_up_reg;
  assign timer_four_irq_o = t4_irq_reg;
  assign timer_five_irq_o = t5_irq_reg;
  assign baud_tick_o = baud_tick_reg;

endmodule : dual_reload_timer_pair

/* verification/timer_pair_checker.sv */
// port-level assertions for the dual reload timer pair
`timescale 1ns/1ps
module timer_pair_checker (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // apb answer side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pin and events
  input wire logic timer_four_pin_o,
  input wire logic timer_four_pin_oe_n_o,
  input wire logic timer_four_pull_up_o,
  input wire logic timer_four_irq_o,
  input wire logic timer_five_irq_o,
  input wire logic baud_tick_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ==========================================
  // register bus answer
  a_ready_after_setup: assert property (psel_i && !penable_i && clk_en_i |=> pready_o)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready_o && clk_en_i |=> !pready_o)
    else $error("answer stands too long");
  a_ready_from_setup: assert property (pready_o && $past(clk_en_i) |-> $past(psel_i) && !$past(penable_i))
    else $error("answer without setup");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error flag outside answer");
  a_rdata_shape: assert property (prdata_o[31:8] == 24'h0 && (pready_o || prdata_o == 32'h0))
    else $error("read data outside byte or answer");

  // ==========================================
  // pin, freeze and reset
  a_pull_up_off: assert property (timer_four_pull_up_o |-> timer_four_pin_oe_n_o)
    else $error("pull-up while pin driven");
  a_pin_moves_driven: assert property ($changed(timer_four_pin_o) |->
    !timer_four_pin_oe_n_o || !$past(timer_four_pin_oe_n_o))
    else $error("pin level moved while not driven");
  a_freeze_hold: assert property (!clk_en_i |=> $stable(pready_o) && $stable(baud_tick_o)
    && $stable(timer_five_irq_o))
    else $error("outputs moved while frozen");
  a_reset_release: assert property ($rose(reset_n_i) |->
    timer_four_pin_oe_n_o && !timer_four_irq_o && !pready_o)
    else $error("outputs not at reset level");

  // main scenarios reached
  c_baud: cover property (baud_tick_o);
  c_compare: cover property ($fell(timer_four_pin_oe_n_o));
  c_irq_five: cover property ($rose(timer_five_irq_o));
endmodule : timer_pair_checker

bind dual_reload_timer_pair timer_pair_checker u_checker (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .timer_four_pin_o(timer_four_pin_o), .timer_four_pin_oe_n_o(timer_four_pin_oe_n_o),
  .timer_four_pull_up_o(timer_four_pull_up_o), .timer_four_irq_o(timer_four_irq_o),
  .timer_five_irq_o(timer_five_irq_o), .baud_tick_o(baud_tick_o)
);

/* verification/testbench.sv */
// self-checking testbench for the dual reload timer pair
`timescale 1ns/1ps
module testbench;
  import timer_pair_pkg::*;
  logic clk, rst_n, en, psel, pen, pwr, pin, clr4, clr5;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, perr, pin_o, oe_n, pull_up, irq4, irq5, baud;
  int num_errors = 0;
  int samples_checked = 0;

  dual_reload_timer_pair DUT (
    .core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(en), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .timer_four_pin_i(pin), .timer_four_pin_o(pin_o),
    .timer_four_pin_oe_n_o(oe_n), .timer_four_pull_up_o(pull_up), .timer_four_flag_clear_i(clr4),
    .timer_five_flag_clear_i(clr5), .timer_four_irq_o(irq4), .timer_five_irq_o(irq5), .baud_tick_o(baud)
  );

  // ==========================================
  // shared helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("BAD pready expected 1 seen 0");
    end
    rd = prdata[7:0];
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'h1, idx, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic e;
    apb(1'h0, idx, 8'h00, r, e);
    check($sformatf("reg %h", idx), {8'h0, exp}, {8'h0, r});
  endtask : rdc

  task automatic wait_irq(input bit five, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((five ? irq5 : irq4) !== 1'h1 && n < 6000);
  endtask : wait_irq

  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================
  // scenarios
  // reset values, unmapped access, short freeze
  task automatic t_reset();
    logic [7:0] r;
    logic e;
    check("oe_n", 16'h1, {15'h0, oe_n});
    rdc(TIMER_FOUR_CONTROL_IDX, 8'h00);
    rdc(TIMER_FOUR_HIGH_IDX, 8'h00);
    pstrb <= 4'h0;
    wr(TIMER_FIVE_CONTROL_IDX, 8'h02);
    pstrb <= 4'h1;
    rdc(TIMER_FIVE_CONTROL_IDX, 8'h00);
    rdc(TIMER_FIVE_LOW_IDX, 8'h00);
    apb(1'h1, 8'h10, 8'h5a, r, e);
    check("slverr", 16'h1, {15'h0, e});
    apb(1'h0, 8'h10, 8'h00, r, e);
    check("unmapped", 16'h0, {8'h0, r});
    en <= 1'h0;
    repeat (3) @(posedge clk);
    en <= 1'h1;
  endtask : t_reset

  // hidden load register versus live counter
  task automatic t_load(input logic [7:0] lo);
    wr(lo, 8'h34);
    wr(lo + 8'h1, 8'h12);
    rdc(lo + 8'h1, 8'h12);
    rdc(lo, 8'h34);
    wr(lo, 8'h56);
    rdc(lo, 8'h34);
  endtask : t_load

  // short run counts up from present value, stop holds
  task automatic t_run(input logic [7:0] ctl, input logic [7:0] lo);
    logic [7:0] r, r2;
    logic e;
    wr(lo + 8'h1, 8'h12);
    wr(ctl, 8'h02);
    wr(ctl, 8'h00);
    rdc(lo + 8'h1, 8'h12);
    apb(1'h0, lo, 8'h00, r, e);
    check("run count", 16'h1, 16'(r > 8'h56 && r < 8'h60));
    repeat (10) @(posedge clk);
    apb(1'h0, lo, 8'h00, r2, e);
    check("stopped", {8'h0, r}, {8'h0, r2});
  endtask : t_run

  // wrap time for each prescale code, reload on wrap
  task automatic t_div(input logic [1:0] code, input bit five);
    int n, d;
    logic [7:0] lo, ctl;
    d = (code == 2'h0) ? 1 : (code == 2'h1) ? 8 : (code == 2'h2) ? 64 : 256;
    lo = five ? TIMER_FIVE_LOW_IDX : TIMER_FOUR_LOW_IDX;
    ctl = five ? TIMER_FIVE_CONTROL_IDX : TIMER_FOUR_CONTROL_IDX;
    wr(lo, 8'hf0);
    wr(lo + 8'h1, 8'hff);
    wr(ctl, {2'h0, code, 4'h2});
    wait_irq(five, n);
    check("div wrap", 16'h1, 16'(n >= 16 * d && n <= 17 * d + 4));
    rdc(lo + 8'h1, 8'hff);
    wr(ctl, 8'h00);
  endtask : t_div

  // flag sets but request stays low when masked
  task automatic t_irq5();
    wr(TIMER_FIVE_IRQ_ENABLE_IDX, 8'h00);
    wr(TIMER_FIVE_CONTROL_IDX, 8'h02);
    repeat (40) @(posedge clk);
    check("irq5 masked", 16'h0, {15'h0, irq5});
    rdc(TIMER_FIVE_CONTROL_IDX, 8'h82);
    wr(TIMER_FIVE_CONTROL_IDX, 8'h80);
    clr5 <= 1'h1;
    @(posedge clk);
    clr5 <= 1'h0;
    rdc(TIMER_FIVE_CONTROL_IDX, 8'h00);
  endtask : t_irq5

  // baud mode ticks without flag or request
  task automatic t_baud();
    int k;
    k = 0;
    wr(TIMER_FOUR_CONTROL_IDX, 8'h06);
    repeat (96) begin
      @(posedge clk);
      k += baud;
      if (irq4 !== 1'h0) k += 100;
    end
    check("baud ticks", 16'h1, 16'(k >= 5 && k <= 7));
    rdc(TIMER_FOUR_CONTROL_IDX, 8'h06);
    wr(TIMER_FOUR_CONTROL_IDX, 8'h00);
  endtask : t_baud

  // compare drives and toggles the pin
  task automatic t_cmp();
    int k;
    logic p;
    k = 0;
    check("oe idle", 16'h1, {15'h0, oe_n});
    wr(TIMER_FOUR_CONTROL_IDX, 8'h42);
    p = pin_o;
    repeat (64) begin
      @(posedge clk);
      if (pin_o !== p) k++;
      p = pin_o;
    end
    check("cmp driven", 16'h0, {15'h0, oe_n});
    check("cmp toggles", 16'h1, 16'(k >= 3 && k <= 5));
    wr(TIMER_FOUR_CONTROL_IDX, 8'h00);
    repeat (2) @(posedge clk);
    check("cmp off", 16'h1, {15'h0, oe_n});
  endtask : t_cmp

  // edge-started count that holds after its wrap
  task automatic t_trig(input logic [1:0] m);
    int n;
    logic [7:0] r;
    logic e;
    pin <= m[0];
    wr(TIMER_FOUR_LOW_IDX, 8'hf0);
    wr(TIMER_FOUR_HIGH_IDX, 8'hff);
    wr(TIMER_FOUR_CONTROL_IDX, {4'h0, m, 2'h3});
    repeat (40) @(posedge clk);
    rdc(TIMER_FOUR_LOW_IDX, 8'hf0);
    pin <= !m[0];
    wait_irq(1'h0, n);
    check("trig wrap", 16'h1, {15'h0, irq4});
    pin <= m[0];
    repeat (30) @(posedge clk);
    rdc(TIMER_FOUR_HIGH_IDX, 8'hff);
    rdc(TIMER_FOUR_LOW_IDX, 8'hf0);
    clr4 <= 1'h1;
    @(posedge clk);
    clr4 <= 1'h0;
    rdc(TIMER_FOUR_CONTROL_IDX, {4'h0, m, 2'h3});
    wr(TIMER_FOUR_CONTROL_IDX, {4'h4, m, 2'h3});
    pin <= !m[0];
    repeat (8) @(posedge clk);
    pin <= m[0];
    repeat (2) @(posedge clk);
    pin <= !m[0];
    apb(1'h0, TIMER_FOUR_LOW_IDX, 8'h00, r, e);
    pin <= m[0];
    check("retrigger", 16'h1, 16'(r < 8'hf8));
    wr(TIMER_FOUR_CONTROL_IDX, 8'h00);
  endtask : t_trig

  // both timers count falling pin edges
  task automatic t_ext();
    wr(TIMER_FOUR_LOW_IDX, 8'h00);
    wr(TIMER_FOUR_HIGH_IDX, 8'h00);
    wr(TIMER_FIVE_LOW_IDX, 8'h00);
    wr(TIMER_FIVE_HIGH_IDX, 8'h00);
    wr(TIMER_FOUR_CONTROL_IDX, 8'h03);
    wr(TIMER_FIVE_CONTROL_IDX, 8'h02);
    check("pull up", 16'h1, {15'h0, pull_up});
    repeat (5) begin
      pin <= 1'h0;
      repeat (4) @(posedge clk);
      pin <= 1'h1;
      repeat (4) @(posedge clk);
    end
    wr(TIMER_FIVE_CONTROL_IDX, 8'h00);
    wr(TIMER_FOUR_CONTROL_IDX, 8'h00);
    rdc(TIMER_FOUR_LOW_IDX, 8'h05);
    rdc(TIMER_FIVE_LOW_IDX, 8'h05);
  endtask : t_ext

  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    rst_n = 1'h0;
    en = 1'h1;
    {psel, pen, pwr, clr4, clr5} = 5'h0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h1;
    pin = 1'h1;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_load(TIMER_FOUR_LOW_IDX);
    t_load(TIMER_FIVE_LOW_IDX);
    t_run(TIMER_FOUR_CONTROL_IDX, TIMER_FOUR_LOW_IDX);
    t_run(TIMER_FIVE_CONTROL_IDX, TIMER_FIVE_LOW_IDX);
    wr(TIMER_FIVE_IRQ_ENABLE_IDX, 8'h01);
    for (int c = 0; c < 8; c++) t_div(2'(c), c[2]);
    t_irq5();
    t_baud();
    t_cmp();
    t_trig(2'h2);
    t_trig(2'h3);
    t_ext();
    summarize();
  end
endmodule : testbench
